//--- logic/dci_params.svh
// constants of the dual-channel input evaluation block
`ifndef DCI_PARAMS_SVH
`define DCI_PARAMS_SVH
`define DCI_CLK_MHZ         100
`define DCI_DELAY_W         24
`define DCI_DISC_W          24
`define DCI_TEST_PERIOD_US  1000
`define DCI_TEST_PERIOD_CYC (`DCI_TEST_PERIOD_US * `DCI_CLK_MHZ)
`define DCI_TEST_PULSE_NS   500
`define DCI_TEST_PULSE_CYC  (`DCI_TEST_PULSE_NS / (1000 / `DCI_CLK_MHZ))
`define DCI_TEST_SETTLE_CYC 20
`define DCI_ERR_NONE        8'h00
`define DCI_ERR_DISC        8'h01
`define DCI_ERR_TEST        8'h02
`endif

//--- logic/dci_pkg.sv
// types of the dual-channel input evaluation block
package dci_pkg;
  typedef enum logic {DCI_COMPLEMENTARY, DCI_EQUIVALENT} dci_mode_e;
  typedef enum logic {DCI_NORMALLY_CLOSED, DCI_NORMALLY_OPEN} dci_contact_e;
  typedef enum logic [1:0] {DCI_T_IDLE, DCI_T_PULSE, DCI_T_CHECK} dci_test_e;
endpackage

//--- logic/dci_filter.sv
// one channel: two-flop synchroniser followed by a stability filter
`include "dci_params.svh"
module dci_filter
  import dci_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    reset,
  input  wire logic                    pin,
  input  wire logic [`DCI_DELAY_W-1:0] delay_cyc,
  input  wire logic                    masked,
  output logic                         level,
  output logic                         raw
);
  logic                    sync1_reg, sync2_reg, sync1_next, sync2_next;
  logic                    level_reg, level_next;
  logic [`DCI_DELAY_W-1:0] cnt_reg, cnt_next;

  always_comb begin
    sync1_next = pin;
    sync2_next = sync1_reg;
    level_next = level_reg;
    cnt_next   = cnt_reg;
    // test pulses are hidden so they never reach the decoded result
    if (masked || sync2_reg == level_reg) begin
      cnt_next = '0;
    end else if (cnt_reg >= delay_cyc) begin
      level_next = sync2_reg;
      cnt_next   = '0;
    end else begin
      cnt_next = cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      level_reg <= 1'b0;
      cnt_reg   <= '0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      level_reg <= level_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign level = level_reg;
  assign raw   = sync2_reg;

  a_filter_hold: assert property (@(posedge mclk) disable iff (reset)
    (masked || sync2_reg == level_reg) |=> $stable(level_reg))
    else $error("filtered level moved without a stable difference");
endmodule

//--- logic/dci_eval.sv
// dual-channel input pair evaluation with testing and discrepancy supervision
`include "dci_params.svh"

module dci_eval
  import dci_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    reset,
  input  wire logic                    ch1_pin,
  input  wire logic                    ch2_pin,
  input  wire logic                    mode_equivalent,
  input  wire logic                    invert_en,
  input  wire logic                    test_en,
  input  wire logic                    contact_no,
  input  wire logic [`DCI_DELAY_W-1:0] delay_cyc,
  input  wire logic [`DCI_DISC_W-1:0]  disc_cyc,
  input  wire logic                    error_clear,
  output logic                         test_out0,
  output logic                         test_out1,
  output logic                         logical_status,
  output logic                         pair_error,
  output logic                         safe_switching_output,
  output logic [7:0]                   error_code
);
  logic ch1_f, ch2_f, ch1_raw, ch2_raw, mask;
  logic logic_val, pair_bad;

  function automatic logic decode_bad(input logic a, input logic b, input logic eqv);
    decode_bad = eqv ? (a != b) : (a == b);
  endfunction

  dci_filter u_f1 (.mclk(mclk), .reset(reset), .pin(ch1_pin), .delay_cyc(delay_cyc),
                   .masked(mask), .level(ch1_f), .raw(ch1_raw));
  dci_filter u_f2 (.mclk(mclk), .reset(reset), .pin(ch2_pin), .delay_cyc(delay_cyc),
                   .masked(mask), .level(ch2_f), .raw(ch2_raw));

  always_comb begin
    pair_bad  = decode_bad(ch1_f, ch2_f, mode_equivalent);
    logic_val = ch1_f ^ invert_en;
  end

  // test pulse generator; the channel is driven low briefly and must follow
  dci_test_e               tst_reg, tst_next;
  logic [31:0]             tcnt_reg, tcnt_next;
  logic                    tout_reg, tout_next, terr_reg, terr_next;
  logic                    actuated, closed, pulse_end;

  always_comb begin
    // closed contact: N/C when not actuated (status 1), N/O when actuated (status 1)
    actuated  = contact_no ? logic_val : ~logic_val;
    closed    = (contact_no && actuated) || (!contact_no && !actuated);
    pulse_end = tst_reg == DCI_T_PULSE && tcnt_reg >= 32'(`DCI_TEST_PULSE_CYC) - 32'd1;
    tst_next  = tst_reg;
    tcnt_next = tcnt_reg + 32'd1;
    tout_next = 1'b1;
    terr_next = terr_reg;
    case (tst_reg)
      DCI_T_IDLE: begin
        // a full count while open lets N/O test at actuation; back-to-back pulses would freeze the filter
        if (!test_en || !closed) begin
          tcnt_next = 32'(`DCI_TEST_PERIOD_CYC);
        end else if (tcnt_reg >= 32'(`DCI_TEST_PERIOD_CYC)) begin
          tst_next  = DCI_T_PULSE;
          tcnt_next = '0;
          tout_next = 1'b0;
        end
      end
      DCI_T_PULSE: begin
        tout_next = 1'b0;
        if (pulse_end) begin
          // both channels must have seen the pulse through the contact
          if (ch1_raw || ch2_raw) terr_next = 1'b1;
          tst_next  = DCI_T_CHECK;
          tcnt_next = '0;
          tout_next = 1'b1;
        end
      end
      DCI_T_CHECK: begin
        if (tcnt_reg >= 32'(`DCI_TEST_SETTLE_CYC)) begin
          tst_next  = DCI_T_IDLE;
          tcnt_next = '0;
        end
      end
      default: tst_next = DCI_T_IDLE;
    endcase
    if (error_clear && !(pulse_end && (ch1_raw || ch2_raw))) terr_next = 1'b0;
    mask = tst_reg != DCI_T_IDLE;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tst_reg  <= DCI_T_IDLE;
      tcnt_reg <= '0;
      tout_reg <= 1'b1;
      terr_reg <= 1'b0;
    end else begin
      tst_reg  <= tst_next;
      tcnt_reg <= tcnt_next;
      tout_reg <= tout_next;
      terr_reg <= terr_next;
    end
  end

  // discrepancy supervision on the filtered levels only, so it starts after the delay
  logic                   p1_reg, p2_reg, run_reg, run_next, derr_reg, derr_next;
  logic [`DCI_DISC_W-1:0] dcnt_reg, dcnt_next;
  logic                   change, expire;

  always_comb begin
    change    = (ch1_f != p1_reg) || (ch2_f != p2_reg);
    expire    = run_reg && dcnt_reg >= disc_cyc;
    run_next  = run_reg;
    dcnt_next = dcnt_reg;
    derr_next = derr_reg;
    if (change && !run_reg) begin
      run_next  = 1'b1;
      dcnt_next = '0;
    end else if (expire) begin
      run_next = 1'b0;
      if (pair_bad) derr_next = 1'b1;
    end else if (run_reg) begin
      dcnt_next = dcnt_reg + 1'b1;
    end
    // a new error in the clearing cycle wins
    if (error_clear && !(expire && pair_bad)) derr_next = 1'b0;
  end

  logic sso_next, status_next;
  logic [7:0] code_next;
  always_comb begin
    status_next = logic_val;
    // the output follows the filtered status without waiting out the discrepancy timer; a bad pair holds it off whenever run_reg is low
    sso_next    = logic_val && !derr_reg && !terr_reg && !(pair_bad && !run_reg);
    code_next   = derr_reg ? `DCI_ERR_DISC : (terr_reg ? `DCI_ERR_TEST : `DCI_ERR_NONE);
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      p1_reg         <= 1'b0;
      p2_reg         <= 1'b0;
      run_reg        <= 1'b0;
      dcnt_reg       <= '0;
      derr_reg       <= 1'b0;
      logical_status <= 1'b0;
      pair_error     <= 1'b0;
      safe_switching_output <= 1'b0;
      error_code     <= `DCI_ERR_NONE;
    end else begin
      p1_reg         <= ch1_f;
      p2_reg         <= ch2_f;
      run_reg        <= run_next;
      dcnt_reg       <= dcnt_next;
      derr_reg       <= derr_next;
      logical_status <= status_next;
      pair_error     <= derr_next || terr_next;
      safe_switching_output <= sso_next;
      error_code     <= code_next;
    end
  end

  assign test_out0 = tout_reg;
  assign test_out1 = tout_reg;

  a_disc_error_off: assert property (@(posedge mclk) disable iff (reset)
    derr_reg |=> !safe_switching_output && error_code == `DCI_ERR_DISC)
    else $error("discrepancy error did not drop the safe output");
  a_disc_expire_err: assert property (@(posedge mclk) disable iff (reset)
    (expire && pair_bad) |=> derr_reg)
    else $error("expired discrepancy not flagged");
  a_disc_start: assert property (@(posedge mclk) disable iff (reset)
    (change && !run_reg) |=> run_reg && dcnt_reg == '0)
    else $error("discrepancy timer did not start on change");
  a_comp_decode: assert property (@(posedge mclk) disable iff (reset)
    (!mode_equivalent && ch1_f != ch2_f) |-> !pair_bad)
    else $error("complementary decode wrong");
  a_equiv_decode: assert property (@(posedge mclk) disable iff (reset)
    (mode_equivalent && ch1_f != ch2_f) |-> pair_bad)
    else $error("equivalent decode wrong");
  a_invert_status: assert property (@(posedge mclk) disable iff (reset)
    1'b1 |=> logical_status == ($past(ch1_f) ^ $past(invert_en)))
    else $error("inversion not applied");
  a_pulse_masked: assert property (@(posedge mclk) disable iff (reset)
    (tst_reg == DCI_T_PULSE) |=> $stable(ch1_f) && $stable(ch2_f))
    else $error("test pulse reached decoded level");
  a_pulse_source: assert property (@(posedge mclk) disable iff (reset)
    (tst_reg == DCI_T_IDLE && tst_next == DCI_T_PULSE) |=> !test_out0 && !test_out1)
    else $error("test outputs did not pulse");
  a_idle_without_test: assert property (@(posedge mclk) disable iff (reset)
    (tst_reg == DCI_T_IDLE && !test_en) |=> tst_reg == DCI_T_IDLE)
    else $error("pulse started without testing enabled");
  a_open_no_pulse: assert property (@(posedge mclk) disable iff (reset)
    (tst_reg == DCI_T_IDLE && !closed) |=> tst_reg == DCI_T_IDLE)
    else $error("pulse started on an open contact");
endmodule

//--- verification/dci_sensor.sv
// behavioural two-contact safety sensor fed by the test outputs
module dci_sensor (
  input  wire logic test_out0,
  input  wire logic test_out1,
  input  wire logic closed1,
  input  wire logic closed2,
  input  wire logic short2,
  output logic      ch1_pin,
  output logic      ch2_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // a closed contact carries its test output back; an open one reads low through the pull-down
  assign ch1_pin = closed1 & test_out0;
  // short2 models channel 2 stuck high, which a test pulse must expose
  assign ch2_pin = (closed2 & test_out1) | short2;
endmodule

//--- verification/dci_eval_test.sv
// self-checking bench for the dual-channel input evaluation block
`include "dci_params.svh"
module dci_eval_test;
  timeunit 1ns;
  timeprecision 1ps;
  // far below the recommended 5 ms so the run stays short; only availability would suffer
  localparam int DLY = 8;
  localparam int DSC = 20;
  logic                    mclk = 1'b0;
  logic                    reset = 1'b1;
  logic                    c1 = 1'b0;
  logic                    c2 = 1'b0;
  logic                    ch1_pin;
  logic                    ch2_pin;
  logic                    mode_equivalent = 1'b1;
  logic                    invert_en = 1'b0;
  logic                    test_en = 1'b0;
  logic                    contact_no = 1'b0;
  logic [`DCI_DELAY_W-1:0] delay_cyc = `DCI_DELAY_W'(DLY);
  logic [`DCI_DISC_W-1:0]  disc_cyc = `DCI_DISC_W'(DSC);
  logic                    error_clear = 1'b0;
  logic                    short2 = 1'b0;
  logic                    test_out0;
  logic                    test_out1;
  logic                    logical_status;
  logic                    pair_error;
  logic                    safe_switching_output;
  logic [7:0]              error_code;
  int                      num_errors = 0;
  int                      n_tests = 0;

  always #5 mclk = ~mclk;

  dci_sensor i_dci_sensor (.test_out0(test_out0), .test_out1(test_out1), .closed1(c1), .closed2(c2),
    .short2(short2), .ch1_pin(ch1_pin), .ch2_pin(ch2_pin));
  dci_eval i_dci_eval (.mclk(mclk), .reset(reset), .ch1_pin(ch1_pin), .ch2_pin(ch2_pin),
    .mode_equivalent(mode_equivalent), .invert_en(invert_en), .test_en(test_en), .contact_no(contact_no),
    .delay_cyc(delay_cyc), .disc_cyc(disc_cyc), .error_clear(error_clear), .test_out0(test_out0),
    .test_out1(test_out1), .logical_status(logical_status), .pair_error(pair_error),
    .safe_switching_output(safe_switching_output), .error_code(error_code));

  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic step(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic clear_err();
    error_clear = 1'b1;
    step(1);
    error_clear = 1'b0;
    step(1);
  endtask

  task automatic t_decode();
    logic bad;
    // start from a good pair so that the first pattern is a level change as well
    c1 = 1'b1;
    c2 = 1'b1;
    step(DLY + DSC + 20);
    for (int m = 0; m < 2; m++) for (int v = 0; v < 2; v++) for (int p = 0; p < 4; p++) begin
      mode_equivalent = m[0];
      invert_en = v[0];
      c1 = p[1];
      c2 = p[0];
      step(DLY + DSC + 20);
      bad = m[0] ? (p[1] != p[0]) : (p[1] == p[0]);
      chk("pair_error", {7'h0, pair_error}, {7'h0, bad});
      if (bad) begin
        chk("error_code", error_code, `DCI_ERR_DISC);
        chk("safe_out", {7'h0, safe_switching_output}, 8'h00);
      end else begin
        chk("status", {7'h0, logical_status}, {7'h0, p[1] ^ v[0]});
        chk("safe_on", {7'h0, safe_switching_output}, {7'h0, p[1] ^ v[0]});
      end
      clear_err();
    end
    $display("decode table done");
  endtask

  task automatic t_disc();
    mode_equivalent = 1'b1;
    invert_en = 1'b0;
    c1 = 1'b0;
    c2 = 1'b0;
    step(DLY + DSC + 20);
    clear_err();
    c1 = 1'b1;
    step(DSC / 2);
    c2 = 1'b1;
    step(DLY + DSC + 20);
    chk("late_match", {7'h0, pair_error}, 8'h00);
    c1 = 1'b0;
    step(DLY + DSC);
    chk("early_err", {7'h0, pair_error}, 8'h00);
    step(20);
    chk("disc_err", {7'h0, pair_error}, 8'h01);
    chk("disc_safe", {7'h0, safe_switching_output}, 8'h00);
    c1 = 1'b1;
    step(DLY + 10);
    clear_err();
    $display("discrepancy timing done");
  endtask

  task automatic t_filter();
    c1 = 1'b0;
    c2 = 1'b0;
    step(DLY + DSC + 20);
    clear_err();
    // a bounce shorter than the delay must never reach the status
    c1 = 1'b1;
    c2 = 1'b1;
    step(DLY / 2);
    c1 = 1'b0;
    c2 = 1'b0;
    step(DLY + 10);
    chk("bounce", {7'h0, logical_status}, 8'h00);
    c1 = 1'b1;
    c2 = 1'b1;
    step(DLY);
    chk("held_early", {7'h0, logical_status}, 8'h00);
    // two synchroniser stages, delay plus one stable cycles, then the output register
    step(3);
    chk("on_edge0", {7'h0, safe_switching_output}, 8'h00);
    step(1);
    chk("on_edge1", {7'h0, safe_switching_output}, 8'h01);
    step(6);
    chk("held_late", {7'h0, logical_status}, 8'h01);
    c1 = 1'b0;
    c2 = 1'b0;
    step(DLY + 3);
    chk("off_edge0", {7'h0, safe_switching_output}, 8'h01);
    step(1);
    chk("off_edge1", {7'h0, safe_switching_output}, 8'h00);
    c1 = 1'b1;
    c2 = 1'b1;
    step(DLY + DSC + 20);
    $display("input delay done");
  endtask

  task automatic t_test();
    int drops;
    int lows;
    drops = 0;
    lows = 0;
    test_en = 1'b1;
    contact_no = 1'b0;
    repeat (400) begin
      step(1);
      if (logical_status !== 1'b1) drops++;
      if (test_out0 === 1'b0 && test_out1 === 1'b0) lows++;
    end
    chk("test_drops", 8'(drops), 8'h00);
    chk("nc_pulse", 8'(lows), 8'(`DCI_TEST_PULSE_CYC));
    chk("test_err", {7'h0, pair_error}, 8'h00);
    // an open normally open contact gets no pulse; actuating it starts one at once
    contact_no = 1'b1;
    c1 = 1'b0;
    c2 = 1'b0;
    lows = 0;
    repeat (DLY + DSC + 20) begin
      step(1);
      if (test_out0 !== 1'b1) lows++;
    end
    chk("no_open", 8'(lows), 8'h00);
    c1 = 1'b1;
    c2 = 1'b1;
    lows = 0;
    repeat (120) begin
      step(1);
      if (test_out0 === 1'b0 && test_out1 === 1'b0) lows++;
    end
    chk("no_pulse", 8'(lows), 8'(`DCI_TEST_PULSE_CYC));
    chk("no_status", {7'h0, logical_status}, 8'h01);
    // a channel stuck high cannot follow the pulse
    test_en = 1'b0;
    step(1);
    short2 = 1'b1;
    test_en = 1'b1;
    step(100);
    chk("test_fault", error_code, `DCI_ERR_TEST);
    chk("fault_safe", {7'h0, safe_switching_output}, 8'h00);
    short2 = 1'b0;
    test_en = 1'b0;
    clear_err();
    chk("fault_clear", {7'h0, pair_error}, 8'h00);
    $display("contact testing done");
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    wrap_up();
  end

  initial begin
    step(5);
    chk("rst_t0", {7'h0, test_out0}, 8'h01);
    chk("rst_t1", {7'h0, test_out1}, 8'h01);
    chk("rst_code", error_code, `DCI_ERR_NONE);
    step(5);
    reset = 1'b0;
    step(2);
    t_decode();
    t_disc();
    t_filter();
    t_test();
    wrap_up();
  end
endmodule
